// file: hw/erx_pkg.sv
// constants and types shared by the mac receive buffer manager
// Function
// - store only frames passing preamble, crc, alignment, length and address checks
// - on bad crc or any error reclaim the buffer, descriptor untouched
// - whole frame with crc goes into one word aligned buffer, 1518/1522 bytes
// - descriptor is two words: buffer address, wrap, ownership; then status
// - descriptor fetched when frame data starts; data written if filter accepts
// - good frame: word 0 rewritten with ownership set, then status word
// - status holds match flags in 31:23, zeros in 22:11, length in 10:0
// - advance to next entry, or wrap on wrap flag or after 1024 entries
// - descriptor address is entry counter ORed with queue pointer
// - owned descriptor: flag unavailable, signal interrupt, drop, refetch next frame
// - each dropped frame counts in a clear on read counter
// - back pressure in half duplex forces a collision on each received frame
// - queue pointer read returns the entry currently accessed
// - source address ignored; no copy while transmitting in half duplex
// - station address stored first four bytes, then last two low bytes
// - station address off on first byte write, on on last byte write
// - all ones broadcast matches only while no broadcast is clear
// - crc of destination gives six bit hash index for unicast or multicast
// - copy all frames stores every frame not blocked by half duplex transmit, once its destination is received
// - extended frame size raises the limit from 1518 to 1522 bytes
// - receive enable gates reception at each frame start; a frame already running completes
package erx_pkg;
	localparam logic [7:0]  OFS_CTL     = 8'h00;
	localparam logic [7:0]  OFS_CFG     = 8'h04;
	localparam logic [7:0]  OFS_QPTR    = 8'h18;
	localparam logic [7:0]  OFS_RSR     = 8'h20;
	localparam logic [7:0]  OFS_DISC    = 8'h6c;
	localparam logic [7:0]  OFS_HASH_LO = 8'h90;
	localparam logic [7:0]  OFS_HASH_HI = 8'h94;
	localparam logic [7:0]  OFS_SA_LO   = 8'h98;
	localparam logic [7:0]  OFS_SA_HI   = 8'h9c;
	localparam logic [7:0]  SA_STRIDE   = 8'h08;
	localparam logic [31:0] RST_CTL     = 32'h0000_0000;
	localparam logic [31:0] RST_CFG     = 32'h0000_0800;
	localparam int          CTL_RE      = 2;
	localparam int          CTL_BP      = 8;
	localparam int          CFG_FD      = 1;
	localparam int          CFG_CAF     = 4;
	localparam int          CFG_NBC     = 5;
	localparam int          CFG_MTI     = 6;
	localparam int          CFG_UNI     = 7;
	localparam int          CFG_BIG     = 8;
	localparam int          RSR_REC     = 0;
	localparam int          RSR_BNA     = 1;
	localparam int          DESC_OWN    = 0;
	localparam int          DESC_WRAP   = 1;
	localparam logic [10:0] MAX_STD     = 11'h5ee;
	localparam logic [10:0] MAX_BIG     = 11'h5f2;
	localparam logic [2:0]  DA_BYTES    = 3'h6;
	localparam logic [31:0] CRC_POLY    = 32'h04c1_1db7;
	localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
	localparam int          N_SA        = 4;

	// bit order matches status word bits 31 down to 23
	typedef struct packed {
		logic            bcast;
		logic            mhash;
		logic            uhash;
		logic            ext;
		logic            unk;
		logic [N_SA-1:0] sa;
	} erx_match_s;

	typedef struct packed {
		logic        req;
		logic        we;
		logic [31:0] addr;
		logic [31:0] wdata;
	} erx_mem_s;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_FETCH = 3'b001,
		S_RECV  = 3'b010,
		S_DROP  = 3'b011,
		S_WB0   = 3'b100,
		S_WB1   = 3'b101
	} erx_state_e;
endpackage

// file: hw/erx_addr_filter.sv
`timescale 1ns/1ps
// destination address filter: station match, hash, broadcast, copy all
module erx_addr_filter
	import erx_pkg::*;
(
	input  wire logic                    core_clk_i, // core clock
	input  wire logic                    nrst_i,     // async reset, low
	input  wire logic                    start_i,    // first byte of a frame starting while enabled
	input  wire logic                    byte_vld_i, // byte strobe
	input  wire logic [7:0]              byte_i,     // frame byte
	input  wire logic                    blk_i,      // transmitting in half duplex
	input  wire logic [31:0]             cfg_i,      // configuration word
	input  wire logic [63:0]             hash_i,     // hash filter bits
	input  wire logic [N_SA-1:0][47:0]   sa_i,       // station addresses
	input  wire logic [N_SA-1:0]         sa_act_i,   // station address active
	output logic                         done_o,     // destination complete
	output logic                         acc_o,      // frame accepted
	output erx_match_s                   match_o     // how it matched
);
	logic [47:0] da_ff, nxt_da;
	logic [31:0] crc_ff, nxt_crc;
	logic [2:0]  cnt_ff, nxt_cnt;
	logic        blk_ff, nxt_blk;
	logic        hbit;
	logic        grp;

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? CRC_POLY : 32'h0000_0000);
		end
		return r;
	endfunction

	always_comb begin
		nxt_da  = da_ff;
		nxt_crc = crc_ff;
		nxt_cnt = cnt_ff;
		nxt_blk = blk_ff;
		if (start_i) begin
			nxt_da  = {40'h00_0000_0000, byte_i};
			nxt_crc = crc_byte(CRC_INIT, byte_i);
			nxt_cnt = 3'h1;
			nxt_blk = blk_i;
		end else if (byte_vld_i && cnt_ff != DA_BYTES) begin
			nxt_da  = {da_ff[39:0], byte_i};
			nxt_crc = crc_byte(crc_ff, byte_i);
			nxt_cnt = cnt_ff + 3'h1;
			nxt_blk = blk_ff | blk_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			da_ff  <= 48'h0000_0000_0000;
			crc_ff <= CRC_INIT;
			cnt_ff <= 3'h0;
			blk_ff <= 1'b0;
		end else begin
			da_ff  <= nxt_da;
			crc_ff <= nxt_crc;
			cnt_ff <= nxt_cnt;
			blk_ff <= nxt_blk;
		end
	end

	// first byte sits in 47:40, so its lsb (group bit) is bit 40
	assign grp  = da_ff[40];
	// top six crc bits index the hash
	assign hbit = hash_i[crc_ff[31:26]];
	assign done_o = (cnt_ff == DA_BYTES);

	assign match_o.bcast = (&da_ff) & ~cfg_i[CFG_NBC];
	assign match_o.mhash = grp & hbit & cfg_i[CFG_MTI];
	assign match_o.uhash = ~grp & hbit & cfg_i[CFG_UNI];
	assign match_o.ext   = 1'b0;
	assign match_o.unk   = 1'b0;

	for (genvar i = 0; i < N_SA; i++) begin : g_sa
		// station 1 lands in the highest flag bit
		assign match_o.sa[N_SA-1-i] = sa_act_i[i] && (da_ff == sa_i[i]);
	end

	// copy all overrides every match; half duplex transmit blocks all
	assign acc_o = done_o && !blk_ff && ((|match_o) || cfg_i[CFG_CAF]);
endmodule

// file: hw/erx_rx_dma.sv
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// receive buffer manager: registers, descriptor walk and frame dma
module erx_rx_dma
	import erx_pkg::*;
#(
	parameter int ENTRIES = 1024, // entries before a forced wrap
	parameter int DISC_W  = 16    // discarded frame counter width
) (
	input  wire logic        core_clk_i,  // 100 MHz core clock
	input  wire logic        nrst_i,      // async reset, low
	input  wire logic [7:0]  reg_addr_i,  // register byte address
	input  wire logic [31:0] reg_wdata_i, // register write data
	input  wire logic        reg_wr_i,    // write strobe
	input  wire logic        reg_rd_i,    // read strobe
	output logic      [31:0] reg_rdata_o, // read data, cycle after strobe
	input  wire logic        rx_valid_i,  // receive byte strobe
	input  wire logic [7:0]  rx_data_i,   // receive byte
	input  wire logic        rx_sof_i,    // first byte of frame
	input  wire logic        rx_eof_i,    // end of frame pulse
	input  wire logic        rx_err_i,    // frame error, with eof
	input  wire logic        tx_active_i, // transmitter busy
	output erx_mem_s         mem_o,       // memory request
	input  wire logic        mem_ack_i,   // memory acknowledge
	input  wire logic [31:0] mem_rdata_i, // memory read data
	output logic             bna_irq_o,   // buffer unavailable pulse
	output logic             bp_jam_o     // force collision pulse
);
	localparam int EW = $clog2(ENTRIES);

	if (ENTRIES < 2 || ENTRIES > 1024 || (ENTRIES & (ENTRIES - 1)) != 0) begin : g_bad_ent
		$error("ENTRIES must be a power of two from 2 to 1024");
	end
	if (DISC_W < 1 || DISC_W > 32) begin : g_bad_disc
		$error("DISC_W must be 1 to 32");
	end

	// register file state
	logic [31:0]           ctl_ff, nxt_ctl;
	logic [31:0]           cfg_ff, nxt_cfg;
	logic [31:0]           qbase_ff, nxt_qbase;
	logic [1:0]            rsr_ff, nxt_rsr;
	logic [DISC_W-1:0]     disc_ff, nxt_disc;
	logic [63:0]           hash_ff, nxt_hash;
	logic [N_SA-1:0][31:0] salo_ff, nxt_salo;
	logic [N_SA-1:0][15:0] sahi_ff, nxt_sahi;
	logic [N_SA-1:0]       act_ff, nxt_act;
	logic [31:0]           rdata_ff, nxt_rdata;
	logic [N_SA-1:0][47:0] sa_pk;

	// dma state
	erx_state_e            st_ff, nxt_st;
	logic [31:0]           desc_ff, nxt_desc;
	logic [10:0]           len_ff, nxt_len;
	logic [31:0]           asm_ff, nxt_asm;
	logic                  pend_ff, nxt_pend;
	logic [31:0]           pwd_ff, nxt_pwd;
	logic [8:0]            pidx_ff, nxt_pidx;
	logic                  err_ff, nxt_err;
	logic                  eof_ff, nxt_eof;
	logic [EW-1:0]         ent_ff, nxt_ent;
	logic                  irq_ff, nxt_irq;
	logic                  jam_ff, nxt_jam;

	logic                  ev_bna;
	logic                  ev_rec;
	logic                  start;
	logic                  coll;
	logic                  flush;
	logic [10:0]           lenb;
	logic [10:0]           maxlen;
	logic [31:0]           cur_desc;
	logic                  filt_done;
	logic                  filt_acc;
	erx_match_s            filt_match;

	// entry counter ORed into the queue pointer; keeps low bits free
	assign cur_desc = qbase_ff | 32'({ent_ff, 3'b000});
	assign maxlen = cfg_ff[CFG_BIG] ? MAX_BIG : MAX_STD;

	always_comb begin
		for (int i = 0; i < N_SA; i++) begin
			// first four bytes above, last two in the low half of the high word
			sa_pk[i] = {salo_ff[i], sahi_ff[i]};
		end
	end

	erx_addr_filter u_filter (
		.core_clk_i (core_clk_i),
		.nrst_i     (nrst_i),
		.start_i    (start),
		.byte_vld_i (rx_valid_i),
		.byte_i     (rx_data_i),
		.blk_i      (tx_active_i && !cfg_ff[CFG_FD]),
		.cfg_i      (cfg_ff),
		.hash_i     (hash_ff),
		.sa_i       (sa_pk),
		.sa_act_i   (act_ff),
		.done_o     (filt_done),
		.acc_o      (filt_acc),
		.match_o    (filt_match)
	);

	always_comb begin
		nxt_ctl   = ctl_ff;
		nxt_cfg   = cfg_ff;
		nxt_qbase = qbase_ff;
		nxt_rsr   = rsr_ff;
		nxt_disc  = disc_ff;
		nxt_hash  = hash_ff;
		nxt_salo  = salo_ff;
		nxt_sahi  = sahi_ff;
		nxt_act   = act_ff;
		nxt_rdata = 32'h0000_0000;
		if (reg_wr_i) begin
			case (reg_addr_i)
				OFS_CTL:     nxt_ctl = reg_wdata_i;
				OFS_CFG:     nxt_cfg = reg_wdata_i;
				OFS_QPTR:    nxt_qbase = reg_wdata_i;
				OFS_RSR:     nxt_rsr = rsr_ff & ~reg_wdata_i[1:0];
				OFS_HASH_LO: nxt_hash[31:0] = reg_wdata_i;
				OFS_HASH_HI: nxt_hash[63:32] = reg_wdata_i;
				default:     nxt_rsr = rsr_ff;
			endcase
			for (int i = 0; i < N_SA; i++) begin
				// writing the first byte disarms, the last byte arms
				if (reg_addr_i == OFS_SA_LO + 8'(i * SA_STRIDE)) begin
					nxt_salo[i] = reg_wdata_i;
					nxt_act[i]  = 1'b0;
				end
				if (reg_addr_i == OFS_SA_HI + 8'(i * SA_STRIDE)) begin
					nxt_sahi[i] = reg_wdata_i[15:0];
					nxt_act[i]  = 1'b1;
				end
			end
		end
		// hardware set wins over a software clear in the same cycle
		if (ev_bna) begin
			nxt_rsr[RSR_BNA] = 1'b1;
		end
		if (ev_rec) begin
			nxt_rsr[RSR_REC] = 1'b1;
		end
		// clear on read, a drop in the read cycle is kept as one
		if (reg_rd_i && reg_addr_i == OFS_DISC) begin
			nxt_disc = ev_bna ? DISC_W'(1) : '0;
		end else if (ev_bna) begin
			nxt_disc = disc_ff + DISC_W'(1);
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				OFS_CTL:     nxt_rdata = ctl_ff;
				OFS_CFG:     nxt_rdata = cfg_ff;
				OFS_QPTR:    nxt_rdata = cur_desc;
				OFS_RSR:     nxt_rdata = {30'h0000_0000, rsr_ff};
				OFS_DISC:    nxt_rdata = 32'(disc_ff);
				OFS_HASH_LO: nxt_rdata = hash_ff[31:0];
				OFS_HASH_HI: nxt_rdata = hash_ff[63:32];
				default:     nxt_rdata = 32'h0000_0000;
			endcase
			for (int i = 0; i < N_SA; i++) begin
				if (reg_addr_i == OFS_SA_LO + 8'(i * SA_STRIDE)) begin
					nxt_rdata = salo_ff[i];
				end
				if (reg_addr_i == OFS_SA_HI + 8'(i * SA_STRIDE)) begin
					nxt_rdata = {16'h0000, sahi_ff[i]};
				end
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctl_ff   <= RST_CTL;
			cfg_ff   <= RST_CFG;
			qbase_ff <= 32'h0000_0000;
			rsr_ff   <= 2'h0;
			disc_ff  <= '0;
			hash_ff  <= 64'h0000_0000_0000_0000;
			salo_ff  <= '0;
			sahi_ff  <= '0;
			act_ff   <= '0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			ctl_ff   <= nxt_ctl;
			cfg_ff   <= nxt_cfg;
			qbase_ff <= nxt_qbase;
			rsr_ff   <= nxt_rsr;
			disc_ff  <= nxt_disc;
			hash_ff  <= nxt_hash;
			salo_ff  <= nxt_salo;
			sahi_ff  <= nxt_sahi;
			act_ff   <= nxt_act;
			rdata_ff <= nxt_rdata;
		end
	end

	assign reg_rdata_o = rdata_ff;

	always_comb begin
		nxt_st   = st_ff;
		nxt_desc = desc_ff;
		nxt_len  = len_ff;
		nxt_asm  = asm_ff;
		nxt_pend = pend_ff;
		nxt_pwd  = pwd_ff;
		nxt_pidx = pidx_ff;
		nxt_err  = err_ff;
		nxt_eof  = eof_ff;
		nxt_ent  = ent_ff;
		ev_bna   = 1'b0;
		ev_rec   = 1'b0;
		start    = 1'b0;
		flush    = 1'b0;
		lenb     = len_ff;
		mem_o    = '0;
		case (st_ff)
			S_IDLE: begin
				// a frame starting while disabled is never seen
				if (rx_valid_i && rx_sof_i && ctl_ff[CTL_RE]) begin
					start    = 1'b1;
					nxt_st   = S_FETCH;
					nxt_err  = 1'b0;
					nxt_eof  = 1'b0;
					nxt_pend = 1'b0;
					lenb     = 11'h000;
				end
			end
			S_FETCH: begin
				// descriptor read as soon as data flows
				mem_o.req  = 1'b1;
				mem_o.addr = cur_desc;
				if (mem_ack_i) begin
					nxt_desc = mem_rdata_i;
					// owned by software: drop, keep the entry for the next frame
					if (mem_rdata_i[DESC_OWN]) begin
						ev_bna = 1'b1;
						nxt_st = (eof_ff || rx_eof_i) ? S_IDLE : S_DROP;
					end else begin
						nxt_st = S_RECV;
					end
				end
			end
			S_RECV: begin
				// nothing reaches memory before the filter accepts
				if (pend_ff && filt_acc && !err_ff) begin
					mem_o.req   = 1'b1;
					mem_o.we    = 1'b1;
					// word aligned buffer, word index from byte count
					mem_o.addr  = {desc_ff[31:2], 2'b00} + {21'h00_0000, pidx_ff, 2'b00};
					mem_o.wdata = pwd_ff;
					if (mem_ack_i) begin
						nxt_pend = 1'b0;
					end
				end
				if (eof_ff) begin
					// error or rejection: buffer reclaimed, descriptor left alone
					if (err_ff || !filt_acc) begin
						nxt_st = S_IDLE;
					end else if (!pend_ff) begin
						nxt_st = S_WB0;
					end
				end
			end
			S_DROP: begin
				if (rx_eof_i) begin
					nxt_st = S_IDLE;
				end
			end
			S_WB0: begin
				// hand the buffer back with ownership set
				mem_o.req   = 1'b1;
				mem_o.we    = 1'b1;
				mem_o.addr  = cur_desc;
				mem_o.wdata = {desc_ff[31:1], 1'b1};
				if (mem_ack_i) begin
					nxt_st = S_WB1;
				end
			end
			S_WB1: begin
				mem_o.req   = 1'b1;
				mem_o.we    = 1'b1;
				mem_o.addr  = cur_desc + 32'h0000_0004;
				mem_o.wdata = {filt_match, 12'h000, len_ff};
				if (mem_ack_i) begin
					ev_rec = 1'b1;
					nxt_st = S_IDLE;
					// wrap on flag or on the last entry
					if (desc_ff[DESC_WRAP] || ent_ff == EW'(ENTRIES - 1)) begin
						nxt_ent = '0;
					end else begin
						nxt_ent = ent_ff + 1'b1;
					end
				end
			end
			default: nxt_st = S_IDLE;
		endcase
		// bytes are packed little endian into words while the frame runs
		coll = start || ((st_ff == S_FETCH || st_ff == S_RECV) && !eof_ff);
		if (coll && rx_valid_i) begin
			nxt_asm[{lenb[1:0], 3'b000} +: 8] = rx_data_i;
			nxt_len = lenb + 11'h001;
			if (lenb == maxlen) begin
				nxt_err = 1'b1;
			end
			flush = (lenb[1:0] == 2'h3);
		end
		if (coll && !start && rx_eof_i) begin
			nxt_eof = 1'b1;
			nxt_err = nxt_err | rx_err_i;
			flush   = (lenb[1:0] != 2'h0);
		end
		// single holding word: memory must drain it before the next word fills
		if (flush) begin
			if (nxt_pend) begin
				nxt_err = 1'b1;
			end
			nxt_pend = 1'b1;
			nxt_pwd  = nxt_asm;
			nxt_pidx = lenb[10:2];
		end
		nxt_irq = ev_bna;
		// the transmitter sends the 64 bit jam pattern on this pulse
		nxt_jam = start && ctl_ff[CTL_BP] && !cfg_ff[CFG_FD];
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_ff   <= S_IDLE;
			desc_ff <= 32'h0000_0000;
			len_ff  <= 11'h000;
			asm_ff  <= 32'h0000_0000;
			pend_ff <= 1'b0;
			pwd_ff  <= 32'h0000_0000;
			pidx_ff <= 9'h000;
			err_ff  <= 1'b0;
			eof_ff  <= 1'b0;
			ent_ff  <= '0;
			irq_ff  <= 1'b0;
			jam_ff  <= 1'b0;
		end else begin
			st_ff   <= nxt_st;
			desc_ff <= nxt_desc;
			len_ff  <= nxt_len;
			asm_ff  <= nxt_asm;
			pend_ff <= nxt_pend;
			pwd_ff  <= nxt_pwd;
			pidx_ff <= nxt_pidx;
			err_ff  <= nxt_err;
			eof_ff  <= nxt_eof;
			ent_ff  <= nxt_ent;
			irq_ff  <= nxt_irq;
			jam_ff  <= nxt_jam;
		end
	end

	assign bna_irq_o = irq_ff;
	assign bp_jam_o  = jam_ff;

	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);

	bna_drop_a: assert property (
		st_ff == S_FETCH && mem_ack_i && mem_rdata_i[DESC_OWN]
		|=> bna_irq_o && rsr_ff[RSR_BNA] && st_ff != S_RECV && $stable(ent_ff))
		else $error("owned descriptor not dropped");
	disc_count_a: assert property (
		ev_bna && !(reg_rd_i && reg_addr_i == OFS_DISC)
		|=> disc_ff == $past(disc_ff) + DISC_W'(1))
		else $error("discard counter missed a drop");
	mark_used_a: assert property (
		st_ff == S_WB0 |-> mem_o.req && mem_o.we && mem_o.wdata[DESC_OWN]
		&& mem_o.addr == cur_desc)
		else $error("descriptor not marked used");
	status_word_a: assert property (
		st_ff == S_WB1 |-> mem_o.wdata[22:11] == 12'h000
		&& mem_o.wdata[10:0] == len_ff && mem_o.addr == cur_desc + 32'h0000_0004)
		else $error("bad status word");
	wrap_clear_a: assert property (
		st_ff == S_WB1 && mem_ack_i && desc_ff[DESC_WRAP] |=> ent_ff == '0)
		else $error("wrap flag did not clear the entry counter");
	entry_step_a: assert property (
		st_ff == S_WB1 && mem_ack_i && !desc_ff[DESC_WRAP] && ent_ff != EW'(ENTRIES - 1)
		|=> ent_ff == $past(ent_ff) + 1'b1)
		else $error("entry counter did not advance");
	gated_write_a: assert property (
		st_ff == S_RECV && mem_o.req |-> filt_acc && !err_ff && pend_ff)
		else $error("data written for a rejected frame");
	reclaim_a: assert property (
		st_ff == S_RECV && eof_ff && err_ff |=> st_ff == S_IDLE ##1 $stable(ent_ff))
		else $error("errored frame not reclaimed");
	rx_enable_a: assert property (
		st_ff == S_IDLE && !ctl_ff[CTL_RE] |=> st_ff == S_IDLE)
		else $error("reception while disabled");
	qptr_read_a: assert property (
		reg_rd_i && reg_addr_i == OFS_QPTR |=> reg_rdata_o == $past(cur_desc))
		else $error("queue pointer read wrong");

	frame_stored_c: cover property (st_ff == S_WB1 && mem_ack_i);
	buffer_busy_c: cover property (bna_irq_o);
	wrap_seen_c: cover property (st_ff == S_WB1 && mem_ack_i && desc_ff[DESC_WRAP]);
	error_drop_c: cover property (st_ff == S_RECV && eof_ff && err_ff);
endmodule

// file: verif/erx_mem_model.sv
`timescale 1ns/1ps
// system memory partner for the receive dma: programmable ack wait
module erx_mem_model
	import erx_pkg::*;
(
	input  wire logic       core_clk_i, // core clock
	input  wire logic       nrst_i,     // async reset, low
	input  wire erx_mem_s   mem_i,      // request from the dma
	input  wire logic [3:0] lat_i,      // wait cycles before ack
	output logic            ack_o,      // one cycle acknowledge
	output logic     [31:0] rdata_o     // read data, ack cycle only
);
	logic [31:0] mem [1024];
	logic [3:0]  wait_ff;
	logic        tog_ff;
	assign ack_o = mem_i.req && (wait_ff == lat_i);
	// no stale word outside the ack cycle, so late sampling shows up
	assign rdata_o = ack_o ? mem[mem_i.addr[11:2]] : {32{tog_ff}} ^ 32'h5a5a_a5a5;
	always @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wait_ff <= 4'h0;
			tog_ff  <= 1'b0;
		end else begin
			wait_ff <= (mem_i.req && !ack_o) ? wait_ff + 4'h1 : 4'h0;
			tog_ff  <= !tog_ff;
			if (ack_o && mem_i.we)
				mem[mem_i.addr[11:2]] <= mem_i.wdata;
		end
	end
endmodule

// file: verif/erx_rx_dma_test.sv
`timescale 1ns/1ps
// self-checking bench for the receive buffer manager
module erx_rx_dma_test
	import erx_pkg::*;
;
	localparam logic [47:0] BC = 48'hffff_ffff_ffff;
	logic        core_clk_i, nrst_i, reg_wr_i, reg_rd_i;
	logic        rx_valid_i, rx_sof_i, rx_eof_i, rx_err_i;
	logic        tx_active_i, mem_ack_i, bna_irq_o, bp_jam_o;
	logic [7:0]  reg_addr_i, rx_data_i;
	logic [31:0] reg_wdata_i, reg_rdata_o, mem_rdata_i, q;
	logic [3:0]  lat;
	erx_mem_s    mem_o;
	int          bad_count = 0;
	int          samples_checked = 0;
	int          bna_n = 0;
	int          jam_n = 0;

	// a short ring keeps the 0x100 queue base aligned for the entry counter
	erx_rx_dma #(.ENTRIES(4), .DISC_W(16)) u_dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
		.reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
		.rx_sof_i(rx_sof_i), .rx_eof_i(rx_eof_i), .rx_err_i(rx_err_i),
		.tx_active_i(tx_active_i), .mem_o(mem_o), .mem_ack_i(mem_ack_i),
		.mem_rdata_i(mem_rdata_i), .bna_irq_o(bna_irq_o), .bp_jam_o(bp_jam_o));
	erx_mem_model u_mem (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .mem_i(mem_o),
		.lat_i(lat), .ack_o(mem_ack_i), .rdata_o(mem_rdata_i));

	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		if (bna_irq_o === 1'b1)
			bna_n <= bna_n + 1;
		if (bp_jam_o === 1'b1)
			jam_n <= jam_n + 1;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic m(input int i, input logic [31:0] e);
		chk(u_mem.mem[i], e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk_i);
		reg_wr_i    <= 1'b1;
		reg_addr_i  <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk_i);
		reg_rd_i   <= 1'b1;
		reg_addr_i <= a;
		@(posedge core_clk_i);
		reg_rd_i <= 1'b0;
		#1;
		q = reg_rdata_o;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(q, e);
	endtask
	// waits until the dma has been quiet on the memory port for a while
	task automatic settle();
		int quiet;
		quiet = 0;
		for (int n = 0; n < 400 && quiet < 12; n++) begin
			@(posedge core_clk_i);
			quiet = (mem_o.req === 1'b1) ? 0 : quiet + 1;
		end
		if (quiet < 12) begin
			bad_count++;
			$display("[FAIL] %0t memory port never went quiet", $time);
			finish_test();
		end
	endtask
	task automatic frame(input logic [47:0] da, input int len, input logic err);
		for (int k = 0; k < len; k++) begin
			@(posedge core_clk_i);
			rx_valid_i <= 1'b1;
			rx_sof_i   <= (k == 0);
			rx_data_i  <= (k < 6) ? da[47 - 8*k -: 8] : 8'(k);
		end
		@(posedge core_clk_i);
		rx_valid_i <= 1'b0;
		rx_sof_i   <= 1'b0;
		rx_eof_i   <= 1'b1;
		rx_err_i   <= err;
		@(posedge core_clk_i);
		rx_eof_i <= 1'b0;
		rx_err_i <= 1'b0;
		settle();
	endtask

	task automatic t_regs();
		rchk(OFS_CTL, RST_CTL);
		rchk(OFS_CFG, RST_CFG);
		rchk(OFS_QPTR, 32'h0);
		rchk(8'h1c, 32'h0);
		wr(OFS_HASH_HI, 32'hc3c3_0f0f);
		rchk(OFS_HASH_HI, 32'hc3c3_0f0f);
		wr(OFS_QPTR, 32'h0000_0100);
		wr(OFS_CTL, 32'h1 << CTL_RE);
	endtask
	task automatic t_good();
		wr(OFS_SA_LO, 32'h0211_2233);
		wr(OFS_SA_HI, 32'h0000_4455);
		frame(48'h0211_2233_4455, 16, 1'b0);
		m(64, 32'h0000_0201);
		m(65, 32'h0400_0010);
		m(128, 32'h3322_1102);
		m(131, 32'h0f0e_0d0c);
		rchk(OFS_QPTR, 32'h0000_0108);
		rd(OFS_RSR);
		chk(q[RSR_REC], 1'b1);
	endtask
	task automatic t_wrap();
		// one wait state: the first data word must drain before the eighth byte
		lat <= 4'h1;
		frame(BC, 16, 1'b0);
		m(66, 32'h0000_0403);
		m(67, 32'h8000_0010);
		m(256, 32'hffff_ffff);
		rchk(OFS_QPTR, 32'h0000_0100);
		lat <= 4'h0;
	endtask
	task automatic t_owned();
		frame(BC, 16, 1'b0);
		chk(bna_n, 1);
		rchk(OFS_DISC, 32'h1);
		rchk(OFS_DISC, 32'h0);
		rchk(OFS_QPTR, 32'h0000_0100);
		rd(OFS_RSR);
		chk(q[RSR_BNA], 1'b1);
		m(65, 32'h0400_0010);
	endtask
	task automatic t_err();
		u_mem.mem[64] = 32'h0000_0200;
		frame(BC, 16, 1'b1);
		m(64, 32'h0000_0200);
		m(65, 32'h0400_0010);
		frame(BC, 1519, 1'b0);
		m(64, 32'h0000_0200);
		rchk(OFS_QPTR, 32'h0000_0100);
		wr(OFS_CFG, RST_CFG | (32'h1 << CFG_BIG));
		frame(BC, 1522, 1'b0);
		m(65, 32'h8000_05f2);
	endtask
	task automatic t_filter();
		u_mem.mem[66] = 32'h0000_0402;
		wr(OFS_CFG, RST_CFG | (32'h1 << CFG_NBC));
		frame(BC, 16, 1'b0);
		m(66, 32'h0000_0402);
		wr(OFS_CFG, RST_CFG | (32'h1 << CFG_CAF));
		tx_active_i <= 1'b1;
		frame(48'h0a0b_0c0d_0e0f, 16, 1'b0);
		m(66, 32'h0000_0402);
		tx_active_i <= 1'b0;
		frame(48'h0a0b_0c0d_0e0f, 16, 1'b0);
		m(66, 32'h0000_0403);
		m(67, 32'h0000_0010);
		wr(OFS_CTL, 32'h0);
		frame(BC, 16, 1'b0);
		chk(bna_n, 1);
	endtask
	task automatic t_jam();
		wr(OFS_CFG, RST_CFG);
		wr(OFS_CTL, (32'h1 << CTL_RE) | (32'h1 << CTL_BP));
		frame(BC, 16, 1'b0);
		chk(jam_n, 1);
		wr(OFS_CFG, RST_CFG | (32'h1 << CFG_FD));
		frame(BC, 16, 1'b0);
		chk(jam_n, 1);
	endtask
	task automatic t_hash();
		// entries 0 and 1 handed back, entry 1 still wraps
		u_mem.mem[64] = 32'h0000_0200;
		u_mem.mem[66] = 32'h0000_0402;
		wr(OFS_HASH_LO, 32'hffff_ffff);
		wr(OFS_HASH_HI, 32'hffff_ffff);
		wr(OFS_CFG, RST_CFG | (32'h1 << CFG_FD) | (32'h1 << CFG_MTI));
		frame(48'h0300_0000_0001, 16, 1'b0);
		m(65, 32'h4000_0010);
		frame(48'h0a0b_0c0d_0e0f, 16, 1'b0);
		m(66, 32'h0000_0402);
		wr(OFS_CFG, RST_CFG | (32'h1 << CFG_FD) | (32'h1 << CFG_UNI));
		frame(48'h0a0b_0c0d_0e0f, 16, 1'b0);
		m(66, 32'h0000_0403);
		m(67, 32'h2000_0010);
	endtask

	initial begin
		{nrst_i, reg_wr_i, reg_rd_i, rx_valid_i, rx_sof_i, rx_eof_i} = 6'h0;
		{rx_err_i, tx_active_i} = 2'h0;
		{reg_addr_i, rx_data_i, reg_wdata_i} = 48'h0;
		lat = 4'h0;
		// buffers handed to the dma, entry 1 wraps
		u_mem.mem[64] = 32'h0000_0200;
		u_mem.mem[66] = 32'h0000_0402;
		repeat (2) @(posedge core_clk_i);
		nrst_i <= 1'b1;
		t_regs();
		t_good();
		t_wrap();
		t_owned();
		t_err();
		t_filter();
		t_jam();
		t_hash();
		finish_test();
	end
endmodule
